// file: rtl/cio_port_block.sv
// Configurable I/O port block: seven ports with muxes, drivers, readback and capture
// Function
// - Seven ports, each pin configured separately; one function per pin.
// - Output mux chooses data-out, latched address, cell output or chip select.
// - Readback buffer presents exactly one source at a time to the host.
// - Readback sources: data-out, cells, direction, control, pin input.
// - Driver enable is logic output enable OR direction bit.
// - Without defined output enable and logic output, direction bit alone drives.
// - First three ports capture as latch, register or direct, strobe or term clocked.
// - Capture outputs feed the logic input bus and are readable by host.
// - Programmed modes fixed; other modes changeable at run time.
// - Control bit 0 gives microcontroller I/O mode on control ports.
// - I/O mode: output driven from data-out, input read via data-in.
// - First four ports lack control registers, default to microcontroller I/O.
// - Logic output tri-stated by product term or cleared direction bit.
// - Address output needs output enable, or direction and control bits set.
// - Address output: fifth, sixth ports low byte; seventh low or high.
// - Control 1 selects address output; all configuration resets to zero.
`timescale 1ns/1ps
module cio_port_block (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire cio_pkg::cio_wr_s host_wr,
  input wire logic [cio_pkg::PORT_SEL_W-1:0] rd_port,
  input wire cio_pkg::cio_rd_e rd_sel,
  input wire logic [cio_pkg::ADDR_W-1:0] host_addr,
  input wire logic address_strobe_input,
  input wire cio_pkg::cio_cfg_s [cio_pkg::NUM_PORTS-1:0] cfg,
  input wire logic [cio_pkg::NUM_PORTS*cio_pkg::PORT_W-1:0] cell_out,
  input wire logic [cio_pkg::NUM_PORTS*cio_pkg::PORT_W-1:0] cell_oe,
  input wire logic [cio_pkg::NUM_PORTS*cio_pkg::PORT_W-1:0] ext_cs,
  input wire logic [cio_pkg::CAP_PORTS*cio_pkg::PORT_W*2-1:0] cap_mode,
  input wire logic [cio_pkg::CAP_PORTS*cio_pkg::PORT_W-1:0] cap_use_term,
  input wire logic [cio_pkg::CAP_PORTS*cio_pkg::PORT_W-1:0] cap_term_clk,
  input wire logic [cio_pkg::NUM_PORTS*cio_pkg::PORT_W-1:0] pin_in,
  output logic [cio_pkg::NUM_PORTS*cio_pkg::PORT_W-1:0] pin_out,
  output logic [cio_pkg::NUM_PORTS*cio_pkg::PORT_W-1:0] pin_oe,
  output logic [cio_pkg::CAP_PORTS*cio_pkg::PORT_W-1:0] logic_in_bus,
  output logic [cio_pkg::PORT_W-1:0] port_readback_buffer
);
  localparam int W = cio_pkg::PORT_W;
  localparam int N = cio_pkg::NUM_PORTS;

  logic [N*W-1:0] dout_r;
  logic [N*W-1:0] dout_nxt;
  logic [N*W-1:0] dir_r;
  logic [N*W-1:0] dir_nxt;
  logic [N*W-1:0] ctrl_r;
  logic [N*W-1:0] ctrl_nxt;
  logic [N*W-1:0] pin_out_r;
  logic [N*W-1:0] pin_out_nxt;
  logic [N*W-1:0] pin_oe_r;
  logic [N*W-1:0] pin_oe_nxt;
  logic [cio_pkg::CAP_PORTS*W-1:0] cap_out;
  logic [cio_pkg::CAP_PORTS*W-1:0] cap_r;
  logic [W-1:0] rb_r;
  logic [W-1:0] rb_nxt;
  logic [cio_pkg::ADDR_W-1:0] addr_latch_r;
  logic [cio_pkg::ADDR_W-1:0] addr_latch_nxt;

  // Host register writes, one bit per pin
  always_comb begin
    dout_nxt = dout_r;
    dir_nxt = dir_r;
    ctrl_nxt = ctrl_r;
    if (host_wr.wr && 32'(host_wr.port) < N) begin
      unique case (host_wr.kind)
        cio_pkg::REG_DATA_OUT: dout_nxt[host_wr.port*W +: W] = host_wr.data;
        cio_pkg::REG_DIR: dir_nxt[host_wr.port*W +: W] = host_wr.data;
        cio_pkg::REG_CTRL: begin
          // Ports without a control register ignore the write
          if (host_wr.port >= cio_pkg::FIRST_CTRL_PORT) begin
            ctrl_nxt[host_wr.port*W +: W] = host_wr.data;
          end
        end
        default: ;
      endcase
    end
  end

  // Address latched while the strobe is high
  always_comb begin
    addr_latch_nxt = address_strobe_input ? host_addr : addr_latch_r;
  end

  // Per-pin output multiplexer and driver enable
  genvar p, b;
  generate
    for (p = 0; p < N; p++) begin : g_port
      for (b = 0; b < W; b++) begin : g_pin
        localparam int K = p*W + b;
        logic is_logic;
        logic addr_mode;
        logic addr_bit;
        always_comb begin
          is_logic = cfg[p].logic_out[b];
          addr_mode = (p >= 32'(cio_pkg::FIRST_CTRL_PORT)) && ctrl_r[K];
          if (p == 32'(cio_pkg::PORT_G) && cfg[p].g_high_byte) begin
            addr_bit = addr_latch_r[W + b];
          end else begin
            addr_bit = addr_latch_r[b];
          end
          // Programmed functions take the pin first, then run-time modes
          if (cfg[p].chip_sel[b]) begin
            pin_out_nxt[K] = ext_cs[K];
          end else if (is_logic) begin
            pin_out_nxt[K] = cell_out[K];
          end else if (addr_mode) begin
            pin_out_nxt[K] = addr_bit;
          end else begin
            pin_out_nxt[K] = dout_r[K];
          end
          if (cfg[p].oe_defined[b] || is_logic || cfg[p].chip_sel[b]) begin
            // Cleared direction bit gates a logic output only without a term
            if (cfg[p].oe_defined[b]) begin
              pin_oe_nxt[K] = cell_oe[K] | dir_r[K];
            end else begin
              pin_oe_nxt[K] = dir_r[K];
            end
          end else begin
            pin_oe_nxt[K] = dir_r[K];
          end
        end
      end
    end
  endgenerate

  // Capture cells on the first three ports
  generate
    for (p = 0; p < cio_pkg::CAP_PORTS; p++) begin : g_cap
      cio_capture_cell u_cap (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin_in(pin_in[p*W +: W]),
        .mode(cap_mode[p*2*W +: 2*W]),
        .use_term(cap_use_term[p*W +: W]),
        .strobe(address_strobe_input),
        .term_clk(cap_term_clk[p*W +: W]),
        .cap_out(cap_out[p*W +: W])
      );
    end
  endgenerate

  // Single-source readback mux
  always_comb begin
    rb_nxt = '0;
    if (32'(rd_port) < N) begin
      unique case (rd_sel)
        cio_pkg::CIO_RD_DOUT: rb_nxt = dout_r[rd_port*W +: W];
        cio_pkg::CIO_RD_CELL: rb_nxt = cell_out[rd_port*W +: W];
        cio_pkg::CIO_RD_DIR: rb_nxt = dir_r[rd_port*W +: W];
        cio_pkg::CIO_RD_CTRL: begin
          if (rd_port >= cio_pkg::FIRST_CTRL_PORT) begin
            rb_nxt = ctrl_r[rd_port*W +: W];
          end
        end
        cio_pkg::CIO_RD_PIN: rb_nxt = pin_in[rd_port*W +: W];
        cio_pkg::CIO_RD_CAP: begin
          if (32'(rd_port) < cio_pkg::CAP_PORTS) begin
            rb_nxt = cap_out[rd_port*W +: W];
          end
        end
        default: rb_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dout_r <= '0;
      dir_r <= {N{cio_pkg::PCR_RESET}};
      ctrl_r <= {N{cio_pkg::PCR_RESET}};
      pin_out_r <= '0;
      pin_oe_r <= '0;
      cap_r <= '0;
      rb_r <= '0;
      addr_latch_r <= '0;
    end else begin
      dout_r <= dout_nxt;
      dir_r <= dir_nxt;
      ctrl_r <= ctrl_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      cap_r <= cap_out;
      rb_r <= rb_nxt;
      addr_latch_r <= addr_latch_nxt;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign logic_in_bus = cap_r;
  assign port_readback_buffer = rb_r;
endmodule

// file: inc/cio_pkg.sv
// Package for the configurable I/O port block: sizes, port indices, selects and carriers
package cio_pkg;
  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 8;
  localparam int CAP_PORTS = 3;
  localparam int ADDR_W = 16;
  localparam int REG_SEL_W = 2;
  localparam int PORT_SEL_W = 3;
  localparam int RD_SEL_W = 3;

  // Port indices
  localparam logic [PORT_SEL_W-1:0] PORT_A = 3'h0;
  localparam logic [PORT_SEL_W-1:0] PORT_E = 3'h4;
  localparam logic [PORT_SEL_W-1:0] PORT_F = 3'h5;
  localparam logic [PORT_SEL_W-1:0] PORT_G = 3'h6;
  localparam logic [PORT_SEL_W-1:0] FIRST_CTRL_PORT = PORT_E;

  // Writable register kinds within the io register space
  localparam logic [REG_SEL_W-1:0] REG_DATA_OUT = 2'h0;
  localparam logic [REG_SEL_W-1:0] REG_DIR = 2'h1;
  localparam logic [REG_SEL_W-1:0] REG_CTRL = 2'h2;

  localparam logic [PORT_W-1:0] PCR_RESET = 8'h00;
  localparam logic [PORT_W-1:0] ALL_ONES = 8'hff;

  // Readback sources
  typedef enum logic [RD_SEL_W-1:0] {
    CIO_RD_DOUT = 3'h0,
    CIO_RD_CELL = 3'h1,
    CIO_RD_DIR = 3'h2,
    CIO_RD_CTRL = 3'h3,
    CIO_RD_PIN = 3'h4,
    CIO_RD_CAP = 3'h5
  } cio_rd_e;

  // Input capture cell modes
  typedef enum logic [1:0] {
    CIO_CAP_DIRECT = 2'h0,
    CIO_CAP_LATCH = 2'h1,
    CIO_CAP_REG = 2'h2
  } cio_cap_e;

  // Fixed per-pin configuration from programming
  typedef struct packed {
    logic [PORT_W-1:0] logic_out;
    logic [PORT_W-1:0] oe_defined;
    logic [PORT_W-1:0] chip_sel;
    logic g_high_byte;
  } cio_cfg_s;

  // Host write request
  typedef struct packed {
    logic wr;
    logic [PORT_SEL_W-1:0] port;
    logic [REG_SEL_W-1:0] kind;
    logic [PORT_W-1:0] data;
  } cio_wr_s;
endpackage

// file: rtl/cio_capture_cell.sv
// Input capture cells for one port: latch, edge register or pass-through
`timescale 1ns/1ps
module cio_capture_cell (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [cio_pkg::PORT_W-1:0] pin_in,
  input wire logic [cio_pkg::PORT_W*2-1:0] mode,
  input wire logic [cio_pkg::PORT_W-1:0] use_term,
  input wire logic strobe,
  input wire logic [cio_pkg::PORT_W-1:0] term_clk,
  output logic [cio_pkg::PORT_W-1:0] cap_out
);
  logic [cio_pkg::PORT_W-1:0] hold_r;
  logic [cio_pkg::PORT_W-1:0] hold_nxt;
  logic [cio_pkg::PORT_W-1:0] prev_r;
  logic [cio_pkg::PORT_W-1:0] prev_nxt;

  genvar i;
  generate
    for (i = 0; i < cio_pkg::PORT_W; i++) begin : g_bit
      logic en;
      logic rise;
      cio_pkg::cio_cap_e m;
      assign m = cio_pkg::cio_cap_e'(mode[2*i+1:2*i]);
      assign en = use_term[i] ? term_clk[i] : strobe;
      assign rise = en & ~prev_r[i];
      always_comb begin
        prev_nxt[i] = en;
        hold_nxt[i] = hold_r[i];
        unique case (m)
          cio_pkg::CIO_CAP_LATCH: if (en) hold_nxt[i] = pin_in[i];
          cio_pkg::CIO_CAP_REG: if (rise) hold_nxt[i] = pin_in[i];
          default: hold_nxt[i] = pin_in[i];
        endcase
        // Latch is transparent while its gate is open
        if (m == cio_pkg::CIO_CAP_DIRECT || (m == cio_pkg::CIO_CAP_LATCH && en)) begin
          cap_out[i] = pin_in[i];
        end else begin
          cap_out[i] = hold_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_r <= '0;
      prev_r <= '0;
    end else begin
      hold_r <= hold_nxt;
      prev_r <= prev_nxt;
    end
  end
endmodule

// file: verif/cio_pin_model.sv
// Pin-side model: outside drivers on released pins
`timescale 1ns/1ps
module cio_pin_model (
  input wire logic [55:0] pin_out,
  input wire logic [55:0] pin_oe,
  input wire logic [55:0] ext_val,
  output logic [55:0] pin_in
);
  // Released pins show the outside value, never the last drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// file: verif/cio_port_block_asserts.sv
// Port-level assertions for the I/O port block
`timescale 1ns/1ps
module cio_port_block_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire cio_pkg::cio_wr_s host_wr,
  input wire logic [2:0] rd_port,
  input wire cio_pkg::cio_rd_e rd_sel,
  input wire logic address_strobe_input,
  input wire cio_pkg::cio_cfg_s [cio_pkg::NUM_PORTS-1:0] cfg,
  input wire logic [55:0] cell_oe,
  input wire logic [47:0] cap_mode,
  input wire logic [23:0] cap_use_term,
  input wire logic [55:0] pin_in,
  input wire logic [55:0] pin_out,
  input wire logic [55:0] pin_oe,
  input wire logic [23:0] logic_in_bus,
  input wire logic [7:0] port_readback_buffer
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr_a(logic [1:0] k);
    host_wr.wr && host_wr.port == 3'h0 && host_wr.kind == k && cfg[0] == '0 ##1 !host_wr.wr;
  endsequence
  property p_rst_zero;
    $past(sys_rst) |-> {pin_out, pin_oe, logic_in_bus, port_readback_buffer} == '0;
  endproperty
  property p_dir_oe;
    s_wr_a(2'h1) |=> pin_oe[7:0] == $past(host_wr.data, 2);
  endproperty
  property p_dout;
    s_wr_a(2'h0) |=> pin_out[7:0] == $past(host_wr.data, 2);
  endproperty
  property p_oe_or;
    (cfg[0].logic_out[0] && cfg[0].oe_defined[0] && cell_oe[0])[*2] |=> pin_oe[0];
  endproperty
  property p_rb_pin;
    (rd_sel == cio_pkg::CIO_RD_PIN && rd_port == 3'h0 && $stable(pin_in[7:0]))[*3]
      |=> port_readback_buffer == $past(pin_in[7:0]);
  endproperty
  property p_rb_bad;
    (rd_port == 3'h7)[*2] |=> port_readback_buffer == 8'h00;
  endproperty
  property p_cap_direct;
    (cap_mode[1:0] == 2'h0 && $stable(pin_in[0]))[*3] |=> logic_in_bus[0] == $past(pin_in[0]);
  endproperty
  property p_cap_hold;
    (cap_mode[1:0] == 2'h1 && !cap_use_term[0] && !address_strobe_input)[*3] |=> $stable(logic_in_bus[0]);
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("outputs not clear after reset");
  a_dir_oe: assert property (p_dir_oe) else $error("pin enable differs from direction");
  a_dout: assert property (p_dout) else $error("pin drive differs from data out");
  a_oe_or: assert property (p_oe_or) else $error("enable term ignored");
  a_rb_pin: assert property (p_rb_pin) else $error("pin readback wrong");
  a_rb_bad: assert property (p_rb_bad) else $error("bad port readback not zero");
  a_cap_direct: assert property (p_cap_direct) else $error("direct capture wrong");
  a_cap_hold: assert property (p_cap_hold) else $error("closed latch moved");
  c_ctrl: cover property (host_wr.wr && host_wr.kind == 2'h2 && host_wr.port > 3'h3);
  c_logic: cover property (p_oe_or);
  c_latch: cover property (p_cap_hold);
  c_edge: cover property (cap_mode[33:32] == 2'h2 && cap_use_term[16]);
endmodule
bind cio_port_block cio_port_block_asserts u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .host_wr(host_wr),
  .rd_port(rd_port), .rd_sel(rd_sel), .address_strobe_input(address_strobe_input), .cfg(cfg),
  .cell_oe(cell_oe), .cap_mode(cap_mode), .cap_use_term(cap_use_term), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .logic_in_bus(logic_in_bus), .port_readback_buffer(port_readback_buffer));

// file: verif/tb_cio_port_block.sv
// Self-checking bench for the I/O port block
`timescale 1ns/1ps
module tb_cio_port_block;
  logic sys_clk, sys_rst, stb;
  cio_pkg::cio_wr_s hw;
  logic [2:0] rp, p;
  cio_pkg::cio_rd_e rs;
  logic [15:0] addr, addr_l;
  cio_pkg::cio_cfg_s [6:0] cfg;
  logic [55:0] co, coe, cs, ext, po, poe, pin;
  logic [47:0] cm;
  logic [23:0] lib, cut, ctc;
  logic [7:0] rb, d;
  logic [1:0] k;
  logic [7:0] m_do[7] = '{default: 8'h00};
  logic [7:0] m_di[7] = '{default: 8'h00};
  logic [7:0] m_ct[7] = '{default: 8'h00};
  int fail_count = 0;
  int n_tests = 0;
  cio_port_block u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .host_wr(hw), .rd_port(rp), .rd_sel(rs),
    .host_addr(addr), .address_strobe_input(stb), .cfg(cfg), .cell_out(co), .cell_oe(coe), .ext_cs(cs),
    .cap_mode(cm), .cap_use_term(cut), .cap_term_clk(ctc), .pin_in(pin), .pin_out(po), .pin_oe(poe),
    .logic_in_bus(lib), .port_readback_buffer(rb));
  cio_pin_model u_pins (.pin_out(po), .pin_oe(poe), .ext_val(ext), .pin_in(pin));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input logic [7:0] e, s, input string n);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task settle;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task wr(input logic [2:0] wp, input logic [1:0] wk, input logic [7:0] wd);
    @(posedge sys_clk);
    hw <= '{1'b1, wp, wk, wd};
    ext <= 56'({$urandom, $urandom});
    @(posedge sys_clk);
    hw.wr <= 1'b0;
    if (wp < 7 && wk == 0) m_do[wp] = wd;
    if (wp < 7 && wk == 1) m_di[wp] = wd;
    if (wp > 3 && wp < 7 && wk == 2) m_ct[wp] = wd;
  endtask
  task rd(input logic [2:0] q, input cio_pkg::cio_rd_e s);
    @(posedge sys_clk);
    rp <= q;
    rs <= s;
    settle;
  endtask
  function automatic cio_pkg::cio_rd_e rsel(input logic [1:0] x);
    return cio_pkg::cio_rd_e'(x == 2'h0 ? 3'h0 : 3'(x) + 3'h1);
  endfunction
  function automatic logic [7:0] exp_rb(input logic [2:0] q, input logic [1:0] x);
    if (q == 3'h7) return 8'h00;
    return x == 0 ? m_do[q] : x == 1 ? m_di[q] : m_ct[q];
  endfunction
  function automatic logic [7:0] exp_pin(input logic [2:0] q);
    logic [7:0] a;
    a = (q == 3'h6) ? addr_l[15:8] : addr_l[7:0];
    return (m_ct[q] & a) | (~m_ct[q] & m_do[q]);
  endfunction
  task test_done;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    test_done;
  end
  initial begin
    {sys_rst, hw, rp, addr, stb, co, coe, cs, ext, cm, cut, ctc} = '0;
    sys_rst = 1'b1;
    rs = cio_pkg::CIO_RD_DOUT;
    cfg = '0;
    cfg[6].g_high_byte = 1'b1;
    void'($urandom(32'h2a81));
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      rd(3'(i / 3), rsel(2'(i % 3)));
      chk(8'h00, rb, "reset value");
    end
    addr_l = 16'($urandom);
    @(posedge sys_clk);
    addr <= addr_l;
    stb <= 1'b1;
    @(posedge sys_clk);
    stb <= 1'b0;
    addr <= ~addr_l;
    wr(3'h4, 2'h2, 8'hff);
    wr(3'h4, 2'h1, 8'hff);
    wr(3'h0, 2'h2, 8'hff);
    wr(3'h7, 2'h0, 8'h5a);
    for (int i = 0; i < 40; i++) begin
      p = 3'($urandom_range(7));
      k = 2'($urandom_range(2));
      d = 8'($urandom);
      wr(p, k, d);
      rd(p, rsel(k));
      chk(exp_rb(p, k), rb, "readback");
      if (p < 7) begin
        chk(exp_pin(p), po[p*8+:8], "pin_out");
        chk(m_di[p], poe[p*8+:8], "pin_oe");
      end
    end
    wr(3'h0, 2'h1, 8'h00);
    rd(3'h0, cio_pkg::CIO_RD_PIN);
    chk(ext[7:0], rb, "pin readback");
    rd(3'h0, cio_pkg::CIO_RD_CAP);
    chk(ext[7:0], rb, "capture readback");
    chk(ext[7:0], lib[7:0], "capture bus");
    rd(3'h3, cio_pkg::CIO_RD_CAP);
    chk(8'h00, rb, "capture on port D");
    @(posedge sys_clk);
    cfg[0].logic_out <= 8'h0f;
    cfg[0].oe_defined <= 8'h0f;
    cfg[1].chip_sel <= 8'hff;
    co <= 56'({$urandom, $urandom});
    coe <= 56'({$urandom, $urandom}) | 56'h1;
    cs <= 56'({$urandom, $urandom});
    wr(3'h0, 2'h1, 8'h30);
    rd(3'h0, cio_pkg::CIO_RD_CELL);
    chk(co[7:0], rb, "cell readback");
    chk({m_do[0][7:4], co[3:0]}, po[7:0], "logic drive");
    chk((coe[7:0] & 8'h0f) | 8'h30, poe[7:0], "logic enable");
    chk(cs[15:8], po[15:8], "chip select");
    @(posedge sys_clk);
    cm[1:0] <= cio_pkg::CIO_CAP_LATCH;
    repeat (6) @(posedge sys_clk);
    // Port C released so its pins show only the outside value
    wr(3'h2, 2'h1, 8'h00);
    d = 8'($urandom);
    @(posedge sys_clk);
    cm[47:32] <= 16'h5555;
    stb <= 1'b1;
    ext[23:16] <= d;
    repeat (2) @(posedge sys_clk);
    stb <= 1'b0;
    ext[23:16] <= ~d;
    rd(3'h2, cio_pkg::CIO_RD_CAP);
    chk(d, rb, "latch readback");
    chk(d, lib[23:16], "latch bus");
    // Edge register clocked by the product term, one rising edge only
    d = 8'($urandom);
    @(posedge sys_clk);
    cm[47:32] <= 16'haaaa;
    cut[23:16] <= 8'hff;
    ext[23:16] <= d;
    @(posedge sys_clk);
    ctc[23:16] <= 8'hff;
    @(posedge sys_clk);
    ext[23:16] <= ~d;
    rd(3'h2, cio_pkg::CIO_RD_CAP);
    chk(d, rb, "edge register readback");
    chk(d, lib[23:16], "edge register bus");
    test_done;
  end
endmodule
